/* File: src/idw_identify_bank.v */
// Identify words 89 to 118 of a flash storage card, reached over APB.
// Assumes one clock (pclk), the card's hardware reset flow driving
// hw_reset_active, and the straps and sense inputs synchronous to pclk.
//
// Overview of operation
// - Word 93 bits 12-0 change only during reset
// - Word 93 bit 15 zero, bit 14 one
// - Bit 13 mirrors sensed cable id level
// - Device 0 zeros 12-8, device 1 zeros 7-0
// - Device 1 bit 11 reports PDIAG asserted
// - Device 1 bits 10-9 give number method
// - Bit 8 set for device 1, bit 0 for device 0
// - Device 0 bit 6 reports responding for device 1
// - Device 0 bit 5 reports DASP seen
// - Device 0 bit 4 reports PDIAG seen
// - Device 0 bit 3 reports diagnostic pass
// - Device 0 bits 2-1 give number method
// - Word 106 sector size fields, top bits 01
// - Words 108-111 carry the world wide name
// - Word 94 recommended and current acoustic values
// - Words 100-103 hold maximum 48-bit LBA
// - Words 89 to 92 read zero
// - Words 117-118 give words per logical sector
// - Streaming and reserved words read zero
`timescale 1ns/1ps
`default_nettype none
`include "idw_regs.vh"

module idw_identify_bank (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        hw_reset_active,
   input  wire        cable_id_high,
   input  wire        is_device1,
   input  wire        pdiag_asserted,
   input  wire        dasp_seen,
   input  wire        diag_passed,
   input  wire        responds_for_dev1,
   input  wire [1:0]  number_method
);

   reg  [12:0] rst_result;
   reg         cable_level;
   reg  [15:0] acoustic;
   reg  [47:0] max_lba;
   reg  [5:0]  sector_cfg;
   reg  [31:0] wwn_hi;
   reg  [31:0] wwn_lo;
   reg  [31:0] words_ls;
   reg  [4:0]  stream_ix;

   reg  [12:0] next_rst_result;
   reg  [31:0] next_rdata;
   reg         next_err;
   reg  [15:0] word_out;
   reg  [15:0] stream_word;
   reg  [15:0] win_word;

   wire        setup_ok;
   wire        commit;
   wire        win_hit;
   wire [4:0]  win_ix;
   wire [15:0] word93;
   wire [15:0] word106;
   wire [1:0]  method;

   // Access phase waits one cycle, so pready and data come from flops
   assign setup_ok = psel & penable & ~pready;
   assign commit   = psel & penable & pready;
   assign win_ix   = paddr[6:2];
   assign win_hit  = (paddr[11:8] == `IDW_WIN_PAGE) && (paddr[7] == 1'b0)
                     && (win_ix <= `IDW_LAST_INDEX) && (paddr[1:0] == 2'h0);

   // Reserved code 00 reported as other or unknown
   assign method = (number_method == 2'h0) ? `IDW_METHOD_OTHER : number_method;

   // Result bits as seen at this moment of the reset
   always @* begin
      if (is_device1) begin
         next_rst_result = {1'b0,
                            pdiag_asserted,
                            method,
                            1'b1,
                            8'h00};
      end else begin
         next_rst_result = {5'h00,
                            1'b0,
                            responds_for_dev1,
                            dasp_seen,
                            pdiag_asserted,
                            diag_passed,
                            method,
                            1'b1};
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_result  <= `IDW_RST_RES_INIT;
         cable_level <= 1'b0;
      end else begin
         cable_level <= cable_id_high;
         if (hw_reset_active) begin
            rst_result <= next_rst_result;
         end
      end
   end

   assign word93  = {`IDW_TOP_BITS, cable_level, rst_result};
   assign word106 = {`IDW_TOP_BITS, sector_cfg[5:4], 8'h00,
                     sector_cfg[`IDW_SECT_RATIO_MSB:0]};

   // One identify word by index; every unlisted word reads zero
   function [15:0] word_at;
      input [4:0] ix;
      begin
         case (ix)
            `IDW_IX_W93:  word_at = word93;
            `IDW_IX_W94:  word_at = acoustic;
            `IDW_IX_W100: word_at = max_lba[15:0];
            `IDW_IX_W101: word_at = max_lba[31:16];
            `IDW_IX_W102: word_at = max_lba[47:32];
            `IDW_IX_W103: word_at = `IDW_ZERO_WORD;
            `IDW_IX_W106: word_at = word106;
            `IDW_IX_W108: word_at = wwn_hi[31:16];
            `IDW_IX_W109: word_at = wwn_hi[15:0];
            `IDW_IX_W110: word_at = wwn_lo[31:16];
            `IDW_IX_W111: word_at = wwn_lo[15:0];
            `IDW_IX_W117: word_at = words_ls[15:0];
            `IDW_IX_W118: word_at = words_ls[31:16];
            default:      word_at = `IDW_ZERO_WORD;
         endcase
      end
   endfunction

   always @* begin
      win_word    = word_at(win_ix);
      stream_word = word_at(stream_ix);
      word_out    = win_hit ? win_word : stream_word;
   end

   // Read data and error for the current request
   always @* begin
      next_rdata = 32'h00000000;
      next_err   = 1'b0;
      if (win_hit) begin
         next_err   = pwrite;
         next_rdata = pwrite ? 32'h00000000 : {16'h0000, word_out};
      end else begin
         case (paddr)
            `IDW_OFS_CTRL:       next_rdata = {27'h0000000, stream_ix};
            `IDW_OFS_STREAM: begin
               next_err   = pwrite;
               next_rdata = pwrite ? 32'h00000000 : {16'h0000, word_out};
            end
            `IDW_OFS_ACOUSTIC:   next_rdata = {16'h0000, acoustic};
            `IDW_OFS_LBA_LO:     next_rdata = max_lba[31:0];
            `IDW_OFS_LBA_HI:     next_rdata = {16'h0000, max_lba[47:32]};
            `IDW_OFS_SECTOR:     next_rdata = {16'h0000, word106};
            `IDW_OFS_WWN_HI:     next_rdata = wwn_hi;
            `IDW_OFS_WWN_LO:     next_rdata = wwn_lo;
            `IDW_OFS_WORDS_LS:   next_rdata = words_ls;
            `IDW_OFS_RST_RESULT: begin
               next_err   = pwrite;
               next_rdata = pwrite ? 32'h00000000 : {16'h0000, word93};
            end
            default:             next_err   = 1'b1;
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_ok;
         if (setup_ok) begin
            prdata  <= next_rdata;
            pslverr <= next_err;
         end else if (commit) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
         end
      end
   end

   // Byte-lane write of a 32-bit configuration word
   function [31:0] lane_merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  st;
      integer      b;
      begin
         lane_merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (st[b]) begin
               lane_merge[b*8 +: 8] = wd[b*8 +: 8];
            end
         end
      end
   endfunction

   wire        wr_ok;
   wire [31:0] acoustic_merged;

   assign wr_ok           = commit & pwrite & ~pslverr;
   // Only the low half of the merged word belongs to word 94
   assign acoustic_merged = lane_merge({16'h0000, acoustic}, pwdata, pstrb);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acoustic   <= `IDW_ACOUSTIC_INIT;
         max_lba    <= `IDW_LBA_INIT;
         sector_cfg <= `IDW_SECTOR_INIT;
         wwn_hi     <= `IDW_WWN_HI_INIT;
         wwn_lo     <= `IDW_WWN_LO_INIT;
         words_ls   <= `IDW_WORDS_LS_INIT;
      end else if (wr_ok) begin
         case (paddr)
            `IDW_OFS_ACOUSTIC: acoustic <= acoustic_merged[15:0];
            `IDW_OFS_LBA_LO:   max_lba[31:0] <= lane_merge(max_lba[31:0], pwdata, pstrb);
            `IDW_OFS_LBA_HI: begin
               if (pstrb[0]) max_lba[39:32] <= pwdata[7:0];
               if (pstrb[1]) max_lba[47:40] <= pwdata[15:8];
            end
            `IDW_OFS_SECTOR: begin
               if (pstrb[1]) sector_cfg[5:4] <= pwdata[`IDW_SECT_MULTI:`IDW_SECT_LONG];
               if (pstrb[0]) sector_cfg[3:0] <= pwdata[`IDW_SECT_RATIO_MSB:0];
            end
            `IDW_OFS_WWN_HI:   wwn_hi   <= lane_merge(wwn_hi, pwdata, pstrb);
            `IDW_OFS_WWN_LO:   wwn_lo   <= lane_merge(wwn_lo, pwdata, pstrb);
            `IDW_OFS_WORDS_LS: words_ls <= lane_merge(words_ls, pwdata, pstrb);
            default: ;
         endcase
      end
   end

   // Stream pointer: each read of the stream word advances one word upward, from word 118 back to word 89
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stream_ix <= 5'h00;
      end else if (commit && !pslverr) begin
         if (pwrite && paddr == `IDW_OFS_CTRL && pstrb[0] && pwdata[`IDW_CTRL_RESTART]) begin
            stream_ix <= 5'h00;
         end else if (!pwrite && paddr == `IDW_OFS_STREAM) begin
            if (stream_ix == `IDW_LAST_INDEX) begin
               stream_ix <= 5'h00;
            end else begin
               stream_ix <= stream_ix + 5'h01;
            end
         end
      end
   end

endmodule // idw_identify_bank

`default_nettype wire

/* File: pkg/idw_regs.vh */
// Constants for the identify words 89 to 118 register bank.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef IDW_REGS_VH
`define IDW_REGS_VH

// APB byte offsets of the control and configuration words
`define IDW_OFS_CTRL        12'h000
`define IDW_OFS_STREAM      12'h004
`define IDW_OFS_ACOUSTIC    12'h008
`define IDW_OFS_LBA_LO      12'h00C
`define IDW_OFS_LBA_HI      12'h010
`define IDW_OFS_SECTOR      12'h014
`define IDW_OFS_WWN_HI      12'h018
`define IDW_OFS_WWN_LO      12'h01C
`define IDW_OFS_WORDS_LS    12'h020
`define IDW_OFS_RST_RESULT  12'h024

// Identify window: word n at WIN_BASE + 4 * (n - FIRST_WORD)
`define IDW_WIN_PAGE        4'h1
`define IDW_FIRST_WORD      8'h59
`define IDW_LAST_WORD       8'h76
`define IDW_WORD_COUNT      5'h1E
`define IDW_LAST_INDEX      5'h1D

// Word indexes inside the window (word number minus 89)
`define IDW_IX_W93          5'h04
`define IDW_IX_W94          5'h05
`define IDW_IX_W100         5'h0B
`define IDW_IX_W101         5'h0C
`define IDW_IX_W102         5'h0D
`define IDW_IX_W103         5'h0E
`define IDW_IX_W106         5'h11
`define IDW_IX_W108         5'h13
`define IDW_IX_W109         5'h14
`define IDW_IX_W110         5'h15
`define IDW_IX_W111         5'h16
`define IDW_IX_W117         5'h1C
`define IDW_IX_W118         5'h1D

// Field positions
`define IDW_CTRL_RESTART    0
`define IDW_W93_CABLE       13
`define IDW_SECT_MULTI      13
`define IDW_SECT_LONG       12
`define IDW_SECT_RATIO_MSB  3

// Device number method codes
`define IDW_METHOD_JUMPER   2'h1
`define IDW_METHOD_CSEL     2'h2
`define IDW_METHOD_OTHER    2'h3

// Fixed top bits of words 93 and 106: bit 15 zero, bit 14 one
`define IDW_TOP_BITS        2'h1

// Reset values
`define IDW_RST_RES_INIT    13'h0000
`define IDW_ACOUSTIC_INIT   16'h0000
`define IDW_LBA_INIT        48'h000000000000
`define IDW_SECTOR_INIT     6'h00
`define IDW_WWN_HI_INIT     32'h00000000
`define IDW_WWN_LO_INIT     32'h00000000
`define IDW_WORDS_LS_INIT   32'h00000000
`define IDW_ZERO_WORD       16'h0000

`endif

/* File: test/idw_checker_sva.sv */
// Concurrent checks on the identify words bank, seen from its ports only.
// Assumes the reset result word is never read while hardware reset runs.
`timescale 1ns/1ps
`default_nettype none
`include "idw_regs.vh"
module idw_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        hw_reset_active,
   input wire logic        cable_id_high,
   input wire logic        is_device1,
   input wire logic        pdiag_asserted,
   input wire logic        dasp_seen,
   input wire logic        diag_passed,
   input wire logic        responds_for_dev1,
   input wire logic [1:0]  number_method
);
   logic [12:0] cap;
   logic [1:0]  mth;
   logic        rd_ok;
   logic        rd_rst;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign mth    = (number_method == 2'b00) ? 2'b11 : number_method;
   assign rd_ok  = pready && !pwrite && !pslverr;
   assign rd_rst = rd_ok && (paddr == `IDW_OFS_RST_RESULT);
   // Expected reset result bits, frozen outside hardware reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cap <= 13'h0000;
      else if (hw_reset_active)
         cap <= is_device1 ? {1'b0, pdiag_asserted, mth, 1'b1, 8'h00}
                           : {6'h00, responds_for_dev1, dasp_seen, pdiag_asserted, diag_passed, mth, 1'b1};
   end
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready high for more than one cycle");
   chk_wait_state: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
      else $error("answer not in second access cycle");
   chk_top_bits: assert property (rd_rst |-> prdata[31:14] == {16'h0000, 2'b01})
      else $error("reset result top bits wrong");
   chk_cable_level: assert property (rd_rst |-> prdata[13] == $past(cable_id_high, 2))
      else $error("cable bit does not follow sensed level");
   chk_reset_capture: assert property (rd_rst |-> prdata[12:0] == cap)
      else $error("reset result bits differ from capture");
   chk_dev_split: assert property (rd_rst |-> prdata[8] != prdata[0]
      && (prdata[8] ? prdata[7:0] == 8'h00 : prdata[12:8] == 5'h00))
      else $error("device half not cleared");
   chk_sector_top: assert property (rd_ok && paddr == `IDW_OFS_SECTOR
      |-> prdata[15:14] == 2'b01 && prdata[11:4] == 8'h00)
      else $error("sector size word fixed bits wrong");
   chk_zero_words: assert property (rd_ok && paddr >= 12'h100 && paddr <= 12'h10C |-> prdata == 32'h00000000)
      else $error("security or power word not zero");
   chk_locked_write: assert property (pready && pwrite && paddr == `IDW_OFS_RST_RESULT |-> pslverr)
      else $error("write to reset result accepted");
endmodule // idw_checker
bind idw_identify_bank idw_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .hw_reset_active(hw_reset_active), .cable_id_high(cable_id_high), .is_device1(is_device1),
   .pdiag_asserted(pdiag_asserted), .dasp_seen(dasp_seen), .diag_passed(diag_passed),
   .responds_for_dev1(responds_for_dev1), .number_method(number_method));
`default_nettype wire

/* File: test/idw_host.sv */
// APB master standing in for the host controller reading identify data.
// Assumes xfer is entered right after a rising edge of pclk.
`timescale 1ns/1ps
`default_nettype none
module idw_host (
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [11:0] paddr,
   output var  logic [31:0] pwdata,
   output var  logic [3:0]  pstrb
);
   initial begin
      {psel, penable, pwrite} = 3'b000;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
   end
   // Request held until pready is sampled high, then released
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
endmodule // idw_host
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the identify words bank.
// Assumes the host model drives APB and the bench drives the reset straps.
`timescale 1ns/1ps
`default_nettype none
`include "idw_regs.vh"
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic        hw_reset_active, cable_id_high, is_device1, pdiag_asserted;
   logic        dasp_seen, diag_passed, responds_for_dev1;
   logic [1:0]  number_method;
   logic [3:0]  pstrb;
   logic [11:0] paddr;
   logic [31:0] prdata, pwdata, r;
   logic [15:0] last93, exp_w [0:29];
   localparam logic [15:0] z0 = 16'h0000;
   int          miscompares = 0, samples_checked = 0, cycles = 0;
   idw_identify_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hw_reset_active(hw_reset_active), .cable_id_high(cable_id_high), .is_device1(is_device1),
      .pdiag_asserted(pdiag_asserted), .dasp_seen(dasp_seen), .diag_passed(diag_passed),
      .responds_for_dev1(responds_for_dev1), .number_method(number_method));
   idw_host host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
   function automatic logic [15:0] w93(input logic c, d1, pd, ds, dg, rs, input logic [1:0] m);
      logic [1:0] mm;
      mm = (m == 2'b00) ? 2'b11 : m;
      return d1 ? {2'b01, c, 1'b0, pd, mm, 1'b1, 8'h00} : {2'b01, c, 5'h00, 1'b0, rs, ds, pd, dg, mm, 1'b1};
   endfunction
   task chk(input logic [11:0] a, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         miscompares++;
         $display("[ERR] addr %h expected %h seen %h", a, x, g);
      end
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      host.xfer(1'b0, a, 32'h00000000, r, e);
      chk(a, {31'h0, xe}, {31'h0, e});
      if (!xe)
         chk(a, x, r);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
      host.xfer(1'b1, a, d, r, e);
      chk(a, {31'h0, xe}, {31'h0, e});
   endtask
   task t_reset_result;
      for (int k = 0; k < 8; k++) begin
         is_device1 <= k[0];
         number_method <= 2'(k[2:1]);
         pdiag_asserted <= k[0] ^ k[1];
         dasp_seen <= k[1];
         diag_passed <= !k[2];
         responds_for_dev1 <= k[2] ^ k[0];
         cable_id_high <= k[1];
         hw_reset_active <= 1'b1;
         last93 = w93(!k[1], k[0], k[0] ^ k[1], k[1], !k[2], k[2] ^ k[0], 2'(k[2:1]));
         repeat (2) @(posedge pclk);
         hw_reset_active <= 1'b0;
         {is_device1, pdiag_asserted, dasp_seen, diag_passed, responds_for_dev1, cable_id_high} <=
            ~{is_device1, pdiag_asserted, dasp_seen, diag_passed, responds_for_dev1, cable_id_high};
         number_method <= ~number_method;
         @(posedge pclk);
         wr(`IDW_OFS_RST_RESULT, 32'h0000FFFF, 1'b1);
         rd(`IDW_OFS_RST_RESULT, {16'h0000, last93}, 1'b0);
         rd(12'h110, {16'h0000, last93}, 1'b0);
      end
   endtask
   task t_config_stream;
      wr(`IDW_OFS_ACOUSTIC, 32'h000080FE, 1'b0);
      wr(`IDW_OFS_LBA_LO, 32'h89ABCDEF, 1'b0);
      wr(`IDW_OFS_LBA_HI, 32'h00004567, 1'b0);
      wr(`IDW_OFS_SECTOR, 32'h00003005, 1'b0);
      wr(`IDW_OFS_WWN_HI, 32'h5ABCDEF1, 1'b0);
      wr(`IDW_OFS_WWN_LO, 32'h23456789, 1'b0);
      wr(`IDW_OFS_WORDS_LS, 32'h00010100, 1'b0);
      exp_w = '{z0, z0, z0, z0, last93, 16'h80FE, z0, z0, z0, z0, z0, 16'hCDEF, 16'h89AB, 16'h4567, z0,
               z0, z0, 16'h7005, z0, 16'h5ABC, 16'hDEF1, 16'h2345, 16'h6789, z0, z0, z0, z0, z0,
               16'h0100, 16'h0001};
      wr(`IDW_OFS_CTRL, 32'h00000001, 1'b0);
      for (int i = 0; i < 30; i++) begin
         rd(`IDW_OFS_STREAM, {16'h0000, exp_w[i]}, 1'b0);
         rd(12'h100 + 12'(4 * i), {16'h0000, exp_w[i]}, 1'b0);
      end
      rd(`IDW_OFS_STREAM, {16'h0000, exp_w[0]}, 1'b0);
      rd(`IDW_OFS_CTRL, 32'h00000001, 1'b0);
      rd(`IDW_OFS_SECTOR, 32'h00007005, 1'b0);
      rd(12'h102, 32'h00000000, 1'b1);
      rd(12'h178, 32'h00000000, 1'b1);
      wr(`IDW_OFS_STREAM, 32'h00000001, 1'b1);
      wr(12'h114, 32'h00000001, 1'b1);
   endtask
   task summarize;
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         summarize;
      end
   end
   initial begin
      presetn = 1'b0;
      {hw_reset_active, cable_id_high, is_device1, pdiag_asserted, dasp_seen, diag_passed} = 6'h00;
      responds_for_dev1 = 1'b0;
      number_method = 2'b00;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset_result;
      t_config_stream;
      summarize;
   end
endmodule // testbench
`default_nettype wire
